// ===== verilog/e1tx_consts.svh
// register offsets, field positions, reset values and timing of the e1 transmit framer
`ifndef E1TX_CONSTS_SVH
`define E1TX_CONSTS_SVH
`define E1TX_A_CTRL 8'h00
`define E1TX_A_PPM 8'h04
`define E1TX_A_MASK 8'h08
`define E1TX_A_IDLE 8'h0C
`define E1TX_A_SALO 8'h10
`define E1TX_A_SAHI 8'h14
`define E1TX_A_SIG 8'h18
`define E1TX_A_STAT 8'h1C
`define E1TX_F_LC 0
`define E1TX_F_SRC 1
`define E1TX_F_SLIP 3
`define E1TX_F_FRM 4
`define E1TX_F_NX 7
`define E1TX_F_PAT 8
`define E1TX_F_AUTO 16
`define E1TX_F_ABIT 0
`define E1TX_F_SIU 1
`define E1TX_F_SIV 2
`define E1TX_F_ACT 4
`define E1TX_F_IDL 8
`define E1TX_F_NMF 12
`define E1TX_RST_MASK 32'hFFFFFFFE
`define E1TX_RST_IDLE 8'hFF
`define E1TX_RST_SA 8'hFF
`define E1TX_RST_NMF 4'hB
`define E1TX_RST_PAT 4'h3
`define E1TX_PAT_LIVE 4'hE
`define E1TX_PPM_MAX 100
`define E1TX_FAS 7'h1B
`define E1TX_MFAS 8'h2F
`define E1TX_CLK_MHZ 250
`define E1TX_CLK_NS 4
`define E1TX_RATE_KBPS 2048
`define E1TX_LOS_NS 2000
`define E1TX_AUTO_US 2000
`endif

// ===== verilog/e1tx_pkg.sv
// types shared by the e1 transmit framer
package e1tx_pkg;
  typedef enum logic [0:0] {E1TX_HDB3 = 1'b0, E1TX_AMI = 1'b1} e1tx_lc_t;
  typedef enum logic [1:0] {
    E1TX_SRC_INT = 2'b00, E1TX_SRC_FIRST = 2'b01, E1TX_SRC_SECOND = 2'b10, E1TX_SRC_EXT = 2'b11
  } e1tx_src_t;
  typedef enum logic [0:0] {E1TX_SLIP_GARB = 1'b0, E1TX_SLIP_EXT = 1'b1} e1tx_slip_t;
  typedef enum logic [2:0] {
    E1TX_PCM31C = 3'b000, E1TX_PCM31 = 3'b001, E1TX_PCM30C = 3'b010,
    E1TX_PCM30 = 3'b011, E1TX_UNFR = 3'b100
  } e1tx_frm_t;
  typedef enum logic [0:0] {E1TX_AU_IDLE = 1'b0, E1TX_AU_LISTEN = 1'b1} e1tx_au_t;
  typedef struct packed {
    e1tx_lc_t lc; e1tx_src_t src; e1tx_slip_t slip; e1tx_frm_t frm; logic nx;
    logic [3:0] pat; logic signed [7:0] ppm; logic [31:0] mask; logic [7:0] idle;
    logic [4:0][7:0] sa; logic abit; logic siu; logic siv;
    logic [3:0] act; logic [3:0] idl; logic [3:0] nmf;
  } e1tx_cfg_t;
  typedef struct packed {
    logic fas; logic crc_mf; logic cas_mf; logic hdb3; logic pat_lock; logic [3:0] pat_id;
  } e1tx_rx_t;
  typedef struct packed {logic pos; logic neg;} e1tx_line_t;
  typedef struct packed {
    e1tx_cfg_t cfg; logic [3:0] s1; logic [3:0] s2; logic [3:0] s3; logic [3:0] lvl;
    logic [31:0] acc; logic [9:0] wd; logic lost;
    logic [2:0] bitc; logic [4:0] ts; logic [3:0] frm; logic [7:0] byte_q;
    logic [3:0] crc; logic [3:0] crc_snap; logic [3:0][1:0] hsym; logic par; logic lastp;
    e1tx_line_t line; logic ten; logic slipt;
    e1tx_au_t au; logic [19:0] aucnt; logic [4:0] seen; logic adone; logic afail;
    logic [31:0] rdata;
  } e1tx_st_t;
endpackage

// ===== verilog/e1tx_framer.sv
// e1 transmit framer: clock choice, framing, payload, signalling, line code, auto setup
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "e1tx_consts.svh"

// ****************************************
// payload fifo
// ****************************************
module e1tx_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; logic [AW-1:0] wp; logic [AW-1:0] rp; logic [CW-1:0] cnt;
  } e1tx_fifo_st_t;
  e1tx_fifo_st_t q, n;
  logic push, pop;

  assign in_ready_o = q.cnt != CW'(D);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data_i;
      n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    n.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ****************************************
// framer top
// ****************************************
module e1tx_framer #(
  parameter int AUTO_CYCLES = `E1TX_AUTO_US * `E1TX_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // timing pins
  input wire logic first_receiver_clk_i,
  input wire logic second_receiver_clk_i,
  input wire logic external_clock_input_i,
  input wire logic garbled_slip_source_i,
  // receive side status for auto configure
  input wire e1tx_pkg::e1tx_rx_t rx_stat_i,
  // payload stream
  input wire logic pl_valid_i,
  input wire logic [7:0] pl_data_i,
  output logic pl_ready_o,
  // line and side outputs
  output e1tx_pkg::e1tx_line_t tx_line_o,
  output logic tx_bit_en_o,
  output logic slip_ref_o,
  output logic [3:0] pattern_o
);
  import e1tx_pkg::*;

  localparam int NCO_BASE =
    int'((64'd1 << 32) * `E1TX_RATE_KBPS / (`E1TX_CLK_MHZ * 1000));
  localparam int PPM_STEP = NCO_BASE / 1000000;
  localparam int LOS_CYC = `E1TX_LOS_NS / `E1TX_CLK_NS;

  function automatic e1tx_st_t rst_st();
    e1tx_st_t r;
    r = '0;
    r.cfg.pat = `E1TX_RST_PAT;
    r.cfg.mask = `E1TX_RST_MASK;
    r.cfg.idle = `E1TX_RST_IDLE;
    r.cfg.sa = {5{`E1TX_RST_SA}};
    r.cfg.nmf = `E1TX_RST_NMF;
    return r;
  endfunction
  localparam e1tx_st_t ST_RST = rst_st();

  function automatic logic crc_on(e1tx_frm_t f);
    return f == E1TX_PCM31C || f == E1TX_PCM30C;
  endfunction

  function automatic logic cas_on(e1tx_frm_t f);
    return f == E1TX_PCM30 || f == E1TX_PCM30C;
  endfunction

  function automatic logic is_pl(e1tx_frm_t f, logic [4:0] ts);
    return f[2] || (ts != 5'h00 && !(cas_on(f) && ts == 5'h10));
  endfunction

  function automatic logic [3:0] abcd(e1tx_cfg_t c, logic [4:0] t);
    return (!c.nx || c.mask[t]) ? c.act : c.idl;
  endfunction

  function automatic logic signed [7:0] clamp_ppm(logic signed [7:0] v);
    if (v > 8'sd100) begin
      return 8'sd100;
    end else if (v < -8'sd100) begin
      return -8'sd100;
    end
    return v;
  endfunction

  // byte for the timeslot that starts now
  function automatic logic [7:0] slot_byte(e1tx_cfg_t c, logic [4:0] ts, logic [3:0] f,
                                           logic [3:0] cs, logic fv, logic [7:0] fd);
    logic [7:0] b;
    logic si;
    logic [2:0] k;
    logic [7:0] mf;
    b = c.idle;
    mf = `E1TX_MFAS;
    k = f[2:0] == 3'h0 ? f[3:1] : f[3:1];
    si = c.siu ? c.siv : 1'b1;
    if (crc_on(c.frm)) begin
      si = f[0] ? mf[3'd7 - k] : cs[2'd3 - f[2:1]];
    end
    if (is_pl(c.frm, ts)) begin
      if ((!c.nx || c.mask[ts]) && fv) begin
        b = fd;
      end
    end else if (ts == 5'h00) begin
      if (!f[0]) begin
        b = {si, `E1TX_FAS};
      end else begin
        b = {si, 1'b1, c.abit, c.sa[0][3'd7 - k], c.sa[1][3'd7 - k],
             c.sa[2][3'd7 - k], c.sa[3][3'd7 - k], c.sa[4][3'd7 - k]};
      end
    end else if (f == 4'h0) begin
      b = {4'h0, c.nmf};
    end else begin
      b = {abcd(c, {1'b0, f}), abcd(c, {1'b1, f})};
    end
    return b;
  endfunction

  e1tx_st_t q, n;
  logic [3:0] agree, lvl_nx, rise;
  logic sel_edge, use_int, nco_carry, tick, pop, out_bit, fb, fv;
  logic [31:0] nco_inc, acc_nx;
  logic [7:0] byte_now, fd;
  logic [3:0] crc_nx;
  logic [1:0] emit;
  logic pol;

  // ****************************************
  // pin synchronisers and clock choice
  // ****************************************
  // a change counts once the second and third stages agree
  assign agree = ~(q.s2 ^ q.s3);
  assign lvl_nx = (agree & q.s3) | (~agree & q.lvl);
  assign rise = lvl_nx & ~q.lvl;

  always_comb begin
    unique case (q.cfg.src)
      E1TX_SRC_FIRST: sel_edge = rise[0];
      E1TX_SRC_SECOND: sel_edge = rise[1];
      E1TX_SRC_EXT: sel_edge = rise[2];
      E1TX_SRC_INT: sel_edge = 1'b0;
    endcase
  end

  // signed offset steps the increment; one step is close to one ppm
  assign nco_inc = 32'(NCO_BASE + int'(q.cfg.ppm) * PPM_STEP);
  assign {nco_carry, acc_nx} = {1'b0, q.acc} + {1'b0, nco_inc};
  assign use_int = q.cfg.src == E1TX_SRC_INT || q.lost;
  assign tick = use_int ? nco_carry : sel_edge;

  // ****************************************
  // frame building
  // ****************************************
  e1tx_fifo #(.W(8), .D(4)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_valid_i(pl_valid_i),
    .in_data_i(pl_data_i),
    .in_ready_o(pl_ready_o),
    .out_valid_o(fv),
    .out_data_o(fd),
    .out_ready_i(pop)
  );

  assign pop = tick && q.bitc == 3'h0 && is_pl(q.cfg.frm, q.ts) &&
               (!q.cfg.nx || q.cfg.mask[q.ts]);
  assign byte_now = q.bitc == 3'h0 ?
    slot_byte(q.cfg, q.ts, q.frm, q.crc_snap, fv, fd) : q.byte_q;
  assign out_bit = byte_now[3'd7 - q.bitc];
  // C bits count as zero while the check sum is formed
  assign fb = (crc_on(q.cfg.frm) && q.ts == 5'h00 && !q.frm[0] && q.bitc == 3'h0) ?
              1'b0 : out_bit;
  assign crc_nx = {q.crc[2:0], 1'b0} ^ ({4{q.crc[3] ^ fb}} & 4'h3);
  assign emit = q.hsym[3];
  assign pol = emit == 2'b01 ? ~q.lastp : q.lastp;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    n.s1 = {garbled_slip_source_i, external_clock_input_i,
            second_receiver_clk_i, first_receiver_clk_i};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.lvl = lvl_nx;
    n.acc = acc_nx;
    n.ten = tick;
    n.slipt = q.cfg.slip == E1TX_SLIP_GARB ? rise[3] : rise[2];
    n.rdata = 32'h0;

    if (q.cfg.src == E1TX_SRC_INT || sel_edge) begin
      n.wd = '0;
      n.lost = 1'b0;
    end else if (q.wd == 10'(LOS_CYC - 1)) begin
      n.lost = 1'b1;
    end else begin
      n.wd = q.wd + 10'h1;
    end

    if (tick) begin
      n.bitc = q.bitc + 3'h1;
      if (q.bitc == 3'h7) begin
        n.ts = q.ts + 5'h1;
        if (q.ts == 5'h1F) begin
          n.frm = q.frm + 4'h1;
        end
      end
      n.byte_q = byte_now;
      n.crc = crc_nx;
      if (q.frm[2:0] == 3'h7 && q.ts == 5'h1F && q.bitc == 3'h7) begin
        n.crc_snap = crc_nx;
        n.crc = 4'h0;
      end
      // four bit look-ahead: a run of four zeros turns into 000V or B00V
      n.hsym = {q.hsym[2:0], out_bit ? 2'b01 : 2'b00};
      if (out_bit) begin
        n.par = ~q.par;
      end else if (q.cfg.lc == E1TX_HDB3 && q.hsym[2:0] == '0) begin
        n.hsym = q.par ? {2'b00, 2'b00, 2'b00, 2'b10} : {2'b01, 2'b00, 2'b00, 2'b10};
        n.par = 1'b0;
      end
      n.line = emit == 2'b00 ? 2'b00 : {pol, ~pol};
      n.lastp = emit == 2'b00 ? q.lastp : pol;
    end

    unique case (q.au)
      E1TX_AU_IDLE: begin
        if (wr_i && addr_i == `E1TX_A_CTRL && wdata_i[`E1TX_F_AUTO]) begin
          n.au = E1TX_AU_LISTEN;
          n.aucnt = '0;
          n.seen = '0;
          n.adone = 1'b0;
          n.afail = 1'b0;
        end
      end
      E1TX_AU_LISTEN: begin
        n.seen = q.seen | {rx_stat_i.fas, rx_stat_i.crc_mf, rx_stat_i.cas_mf,
                           rx_stat_i.hdb3, rx_stat_i.pat_lock};
        n.aucnt = q.aucnt + 20'h1;
        if (q.aucnt == 20'(AUTO_CYCLES - 1)) begin
          n.au = E1TX_AU_IDLE;
          n.adone = 1'b1;
          n.cfg.lc = n.seen[1] ? E1TX_HDB3 : E1TX_AMI;
          n.cfg.pat = n.seen[0] ? rx_stat_i.pat_id : `E1TX_PAT_LIVE;
          if (n.seen[4]) begin
            n.cfg.frm = e1tx_frm_t'({1'b0, n.seen[2], ~n.seen[3]});
          end else begin
            n.cfg.frm = E1TX_UNFR;
            n.afail = ~n.seen[0];
          end
        end
      end
    endcase

    // software writes land after auto configure and win over it
    if (wr_i) begin
      case (addr_i)
        `E1TX_A_CTRL: begin
          n.cfg.lc = e1tx_lc_t'(wdata_i[`E1TX_F_LC]);
          n.cfg.src = e1tx_src_t'(wdata_i[`E1TX_F_SRC +: 2]);
          n.cfg.slip = e1tx_slip_t'(wdata_i[`E1TX_F_SLIP]);
          n.cfg.frm = e1tx_frm_t'(wdata_i[`E1TX_F_FRM +: 3]);
          n.cfg.nx = wdata_i[`E1TX_F_NX];
          n.cfg.pat = wdata_i[`E1TX_F_PAT +: 4];
        end
        `E1TX_A_PPM: n.cfg.ppm = clamp_ppm(wdata_i[7:0]);
        `E1TX_A_MASK: n.cfg.mask = wdata_i;
        `E1TX_A_IDLE: n.cfg.idle = wdata_i[7:0];
        `E1TX_A_SALO: n.cfg.sa[3:0] = wdata_i;
        `E1TX_A_SAHI: n.cfg.sa[4] = wdata_i[7:0];
        `E1TX_A_SIG: begin
          n.cfg.abit = wdata_i[`E1TX_F_ABIT];
          n.cfg.siu = wdata_i[`E1TX_F_SIU];
          n.cfg.siv = wdata_i[`E1TX_F_SIV];
          n.cfg.act = wdata_i[`E1TX_F_ACT +: 4];
          n.cfg.idl = wdata_i[`E1TX_F_IDL +: 4];
          n.cfg.nmf = wdata_i[`E1TX_F_NMF +: 4];
        end
        default: begin
        end
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        `E1TX_A_CTRL: n.rdata = {20'h0, q.cfg.pat, q.cfg.nx, q.cfg.frm, q.cfg.slip,
                                 q.cfg.src, q.cfg.lc};
        `E1TX_A_PPM: n.rdata = {{24{q.cfg.ppm[7]}}, q.cfg.ppm};
        `E1TX_A_MASK: n.rdata = q.cfg.mask;
        `E1TX_A_IDLE: n.rdata = {24'h0, q.cfg.idle};
        `E1TX_A_SALO: n.rdata = q.cfg.sa[3:0];
        `E1TX_A_SAHI: n.rdata = {24'h0, q.cfg.sa[4]};
        `E1TX_A_SIG: n.rdata = {16'h0, q.cfg.nmf, q.cfg.idl, q.cfg.act, 1'b0,
                                q.cfg.siv, q.cfg.siu, q.cfg.abit};
        `E1TX_A_STAT: n.rdata = {27'h0, use_int, q.afail, q.adone,
                                 q.au == E1TX_AU_LISTEN, q.lost};
        default: n.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign rdata_o = q.rdata;
  assign tx_line_o = q.line;
  assign tx_bit_en_o = q.ten;
  assign slip_ref_o = q.slipt;
  assign pattern_o = q.cfg.pat;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  logic fas_slot, nfas_slot, ts16_slot;
  assign fas_slot = tick && !q.cfg.frm[2] && q.ts == 5'h00 && q.bitc == 3'h0;
  assign nfas_slot = fas_slot && q.frm[0];
  assign ts16_slot = tick && cas_on(q.cfg.frm) && q.ts == 5'h10 && q.bitc == 3'h0;

  fallback_set_a: assert property (
    (q.cfg.src != E1TX_SRC_INT && !sel_edge && !q.lost && q.wd == 10'(LOS_CYC - 1))
      |=> q.lost ##1 (tx_bit_en_o == $past(nco_carry)))
    else $error("transmit clock did not fall back to internal");
  ext_clock_a: assert property (
    (q.cfg.src == E1TX_SRC_EXT && !q.lost && rise[2]) |=> tx_bit_en_o)
    else $error("external edge did not clock the transmitter");
  ppm_range_a: assert property (
    q.cfg.ppm <= 8'sd100 && q.cfg.ppm >= -8'sd100)
    else $error("clock offset out of range");
  line_excl_a: assert property (
    !(tx_line_o.pos && tx_line_o.neg) && (tx_line_o == $past(tx_line_o) || $past(tick)))
    else $error("bad line symbol");
  slip_pick_a: assert property (
    (q.cfg.slip == E1TX_SLIP_EXT && rise[2]) |=> slip_ref_o)
    else $error("slip reference not taken from external input");
  fas_word_a: assert property (
    (fas_slot && !q.frm[0]) |-> byte_now[6:0] == `E1TX_FAS)
    else $error("frame alignment word wrong");
  nfas_bits_a: assert property (
    nfas_slot |-> byte_now[6:5] == {1'b1, q.cfg.abit} &&
                  byte_now[4] == q.cfg.sa[0][3'd7 - q.frm[3:1]])
    else $error("spare or A bit wrong");
  idle_fill_a: assert property (
    (tick && q.bitc == 3'h0 && q.cfg.nx && !q.cfg.mask[q.ts] && is_pl(q.cfg.frm, q.ts))
      |-> byte_now == q.cfg.idle)
    else $error("idle byte missing in unselected timeslot");
  cas_word_a: assert property (
    (ts16_slot && q.frm == 4'h0) |-> byte_now == {4'h0, q.cfg.nmf})
    else $error("multiframe word wrong");
  abcd_act_a: assert property (
    (ts16_slot && q.frm != 4'h0 && !q.cfg.nx) |-> byte_now[7:4] == q.cfg.act)
    else $error("active signalling word wrong");
  auto_fail_a: assert property (
    (q.au == E1TX_AU_LISTEN && q.aucnt == 20'(AUTO_CYCLES - 1) && !wr_i &&
     !(q.seen[4] || rx_stat_i.fas) && !(q.seen[0] || rx_stat_i.pat_lock))
      |=> q.cfg.frm == E1TX_UNFR && pattern_o == `E1TX_PAT_LIVE && q.afail)
    else $error("failed auto configure did not fall back");

  fallback_c: cover property (q.cfg.src != E1TX_SRC_INT ##1 q.lost);
  hdb3_c: cover property (tick && q.cfg.lc == E1TX_HDB3 && n.hsym[0] == 2'b10);
  pop_c: cover property (pop && fv && q.cfg.nx);
  auto_c: cover property (q.au == E1TX_AU_LISTEN ##1 q.au == E1TX_AU_IDLE && q.adone);
endmodule

// ===== dv/e1tx_line_model.sv
// far-end timing sources seen by the e1 transmit framer
`timescale 1ns/1ns
module e1tx_line_model (
  // run controls from the bench
  input wire logic ext_run_i,
  input wire logic rx_run_i,
  // timing pins toward the framer
  output logic first_clk_o,
  output logic second_clk_o,
  output logic ext_clk_o,
  output logic slip_src_o
);
  // a stopped source stands low: a dead line gives no edges at all
  initial begin
    first_clk_o = 1'b0;
    second_clk_o = 1'b0;
    ext_clk_o = 1'b0;
    slip_src_o = 1'b0;
  end
  // periods of 64, 68, 76 and 160 ns, each a whole multiple of the 4 ns system clock
  always #32 ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b0;
  always #34 first_clk_o = rx_run_i ? ~first_clk_o : 1'b0;
  always #38 second_clk_o = rx_run_i ? ~second_clk_o : 1'b0;
  always #80 slip_src_o = ~slip_src_o;
endmodule

// ===== dv/e1tx_framer_tb.sv
// self-checking bench of the e1 transmit framer
`timescale 1ns/1ns
`include "e1tx_consts.svh"
module e1tx_framer_tb;
  import e1tx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic first_clk, second_clk, ext_clk, slip_src;
  logic ext_run = 1'b0;
  logic rx_run = 1'b0;
  e1tx_rx_t rx_stat_i = '0;
  logic pl_valid_i = 1'b0;
  logic [7:0] pl_data_i = 8'h00;
  logic pl_ready_o, tx_bit_en_o, slip_ref_o;
  e1tx_line_t tx_line_o;
  logic [3:0] pattern_o;
  int fails = 0;
  int check_count = 0;
  logic [31:0] d;

  always #2 clk_sys_i = ~clk_sys_i;

  e1tx_framer #(.AUTO_CYCLES(64)) i_e1tx_framer (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_receiver_clk_i(first_clk),
    .second_receiver_clk_i(second_clk), .external_clock_input_i(ext_clk),
    .garbled_slip_source_i(slip_src), .rx_stat_i(rx_stat_i), .pl_valid_i(pl_valid_i),
    .pl_data_i(pl_data_i), .pl_ready_o(pl_ready_o), .tx_line_o(tx_line_o),
    .tx_bit_en_o(tx_bit_en_o), .slip_ref_o(slip_ref_o), .pattern_o(pattern_o));

  e1tx_line_model i_e1tx_line_model (
    .ext_run_i(ext_run), .rx_run_i(rx_run), .first_clk_o(first_clk),
    .second_clk_o(second_clk),
    .ext_clk_o(ext_clk), .slip_src_o(slip_src));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    // one idle edge so a following write never re-raises the strobe in this time step
    @(posedge clk_sys_i);
  endtask
  // read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_sys_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, exp);
  endtask
  // counts marks and same-polarity repeats over n transmitted bits
  task automatic marks(input int n, output int m, output int v);
    logic lastp;
    m = 0;
    v = 0;
    lastp = 1'b0;
    repeat (n) begin
      do @(posedge clk_sys_i); while (tx_bit_en_o !== 1'b1);
      if (tx_line_o.pos === 1'b1 || tx_line_o.neg === 1'b1) begin
        m++;
        if (m > 1 && tx_line_o.pos === lastp) v++;
        lastp = tx_line_o.pos;
      end
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk(32'(pattern_o), `E1TX_RST_PAT);
    chk(32'(pl_ready_o), 32'h1);
    rchk(`E1TX_A_CTRL, 32'h300, 32'hFFFFFFFF);
    rchk(`E1TX_A_MASK, `E1TX_RST_MASK, 32'hFFFFFFFF);
    rchk(`E1TX_A_IDLE, 32'hFF, 32'hFFFFFFFF);
    rchk(`E1TX_A_SALO, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rchk(`E1TX_A_STAT, 32'h10, 32'h1F);
    rchk(8'h20, 32'h0, 32'hFFFFFFFF);
  endtask
  task automatic t_ppm();
    wr(`E1TX_A_PPM, 32'h7F);
    rchk(`E1TX_A_PPM, 32'h64, 32'hFFFFFFFF);
    wr(`E1TX_A_PPM, 32'hFFFFFF80);
    rchk(`E1TX_A_PPM, 32'hFFFFFF9C, 32'hFFFFFFFF);
    wr(`E1TX_A_PPM, 32'hFFFFFFFB);
    rchk(`E1TX_A_PPM, 32'hFFFFFFFB, 32'hFFFFFFFF);
  endtask
  task automatic t_src();
    ext_run <= 1'b1;
    rx_run <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wr(`E1TX_A_CTRL, 32'(s) << 1);
      cyc(600);
      rchk(`E1TX_A_STAT, 32'h0, 32'h11);
    end
    ext_run <= 1'b0;
    cyc(600);
    rchk(`E1TX_A_STAT, 32'h11, 32'h11);
    ext_run <= 1'b1;
    cyc(600);
    rchk(`E1TX_A_STAT, 32'h0, 32'h11);
  endtask
  task automatic t_slip(input logic [31:0] ctrl, input int lo, input int hi);
    int n;
    n = 0;
    wr(`E1TX_A_CTRL, ctrl);
    cyc(20);
    repeat (640) begin
      @(posedge clk_sys_i);
      if (slip_ref_o === 1'b1) n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic t_code(input logic [31:0] ctrl, input logic [7:0] idle, output int m,
                        output int v);
    wr(`E1TX_A_CTRL, ctrl);
    wr(`E1TX_A_IDLE, {24'h0, idle});
    marks(16, m, v);
    marks(32, m, v);
  endtask
  task automatic t_frame(input logic [31:0] sig, input logic [7:0] sa4, input int exp);
    int m, v;
    wr(`E1TX_A_SIG, sig);
    wr(`E1TX_A_SALO, {24'h0, sa4});
    marks(16, m, v);
    marks(512, m, v);
    chk(32'(m), 32'(exp));
  endtask
  task automatic t_auto(input e1tx_rx_t rx, input logic [31:0] ctrl, input logic [3:0] pat,
                        input logic [31:0] stat);
    rx_stat_i <= rx;
    wr(`E1TX_A_CTRL, 32'h00010006);
    cyc(2);
    rchk(`E1TX_A_STAT, 32'h2, 32'hE);
    cyc(80);
    rchk(`E1TX_A_STAT, stat, 32'hE);
    rchk(`E1TX_A_CTRL, ctrl, 32'h71);
    chk(32'(pattern_o), 32'(pat));
  endtask
  task automatic t_fifo();
    wr(`E1TX_A_CTRL, 32'h46);
    // stop the bit clock first so no slot drains the fifo while it fills
    ext_run <= 1'b0;
    cyc(20);
    pl_valid_i <= 1'b1;
    for (int i = 0; i < 8 && pl_ready_o; i++) begin
      pl_data_i <= 8'hA0 + 8'(i);
      @(posedge clk_sys_i);
    end
    pl_valid_i <= 1'b0;
    chk(32'(pl_ready_o), 32'h0);
    cyc(200);
    chk(32'(pl_ready_o), 32'h0);
    ext_run <= 1'b1;
    cyc(900);
    chk(32'(pl_ready_o), 32'h1);
  endtask
  // n x 64k: only timeslot 1 carries the zero payload, all others the idle ones
  task automatic t_nx();
    int m, v;
    wr(`E1TX_A_MASK, 32'h2);
    wr(`E1TX_A_IDLE, 32'hFF);
    wr(`E1TX_A_CTRL, 32'hC7);
    pl_data_i <= 8'h00;
    pl_valid_i <= 1'b1;
    cyc(4);
    pl_valid_i <= 1'b0;
    marks(16, m, v);
    marks(256, m, v);
    chk(32'(m), 32'd248);
    chk(32'(v), 32'd0);
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (70000) @(posedge clk_sys_i);
    fails++;
    complete_run();
  end

  initial begin
    int m, v;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_ppm();
    t_src();
    t_slip(32'h08, 39, 41);
    t_slip(32'h00, 15, 17);
    t_code(32'h47, 8'hFF, m, v);
    chk(32'(m), 32'd32);
    chk(32'(v), 32'd0);
    t_code(32'h47, 8'h00, m, v);
    chk(32'(m), 32'd0);
    t_code(32'h46, 8'h00, m, v);
    chk(32'(m > 0 && v > 0), 32'h1);
    wr(`E1TX_A_CTRL, 32'h17);
    wr(`E1TX_A_SAHI, 32'h0);
    t_frame(32'h0, 8'h00, 7);
    t_frame(32'h3, 8'hFF, 7);
    t_auto('{fas: 1'b0, crc_mf: 1'b0, cas_mf: 1'b0, hdb3: 1'b0, pat_lock: 1'b0,
             pat_id: 4'h0}, 32'h41, `E1TX_PAT_LIVE, 32'hC);
    t_auto('{fas: 1'b1, crc_mf: 1'b1, cas_mf: 1'b0, hdb3: 1'b1, pat_lock: 1'b1,
             pat_id: 4'h5}, 32'h00, 4'h5, 32'h4);
    t_auto('{fas: 1'b1, crc_mf: 1'b0, cas_mf: 1'b1, hdb3: 1'b0, pat_lock: 1'b1,
             pat_id: 4'h9}, 32'h31, 4'h9, 32'h4);
    t_fifo();
    t_nx();
    complete_run();
  end
endmodule
